// [hdl/slvc_pkg.sv]
package slvc_pkg;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int NUM_CH        = 40;
    localparam int NUM_SLICE     = 3;
    localparam int CLK_PERIOD_NS = 50;
    localparam int FLASH_HALF_NS = 250_000_000;
    localparam int FLASH_CYC     = FLASH_HALF_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS    = 8'h00;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h08;
    localparam logic [7:0] OFS_OUT_MODE  = 8'h0c;
    localparam logic [7:0] OFS_FB_MODE   = 8'h10;
    localparam logic [7:0] OFS_FB_SEL_LO = 8'h14;
    localparam logic [7:0] OFS_FB_SEL_HI = 8'h18;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int MODE_W       = 3;
    localparam int MODE_TBL_W   = 4 * MODE_W;
    localparam int STAT_EJ_TOP  = 8;
    localparam int STAT_EJ_BOT  = 9;
    localparam int IRQ_W        = 4;
    localparam int IRQ_EJ_TOP   = 0;
    localparam int IRQ_EJ_BOT   = 1;
    localparam int IRQ_DISAGREE = 2;
    localparam int IRQ_FATAL    = 3;
    localparam logic [11:0] RST_OUT_MODE  = 12'hb90;
    localparam logic [11:0] RST_FB_MODE   = 12'hb88;
    localparam logic [31:0] RST_FB_SEL_LO = 32'hffffff00;
    localparam logic [7:0]  RST_FB_SEL_HI = 8'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        M_OFF, M_GRN, M_RED, M_GRN_FL, M_RED_FL, M_AMB, M_AMB_FL
    } slvc_mode_t;

    typedef enum logic [2:0] {
        H_NOPWR, H_PWRON, H_START, H_OK, H_FAULT, H_FATAL
    } slvc_health_t;

    typedef struct packed {
        logic active;
        logic maintain;
        logic standby;
        logic shutdown;
        logic fatal;
        logic educated;
        logic recognised;
        logic changeover;
    } slvc_mod_t;

    typedef struct packed {
        slvc_health_t        health;
        slvc_mod_t           mod;
        logic [NUM_CH-1:0]   ch_on;
        logic [NUM_CH-1:0]   ch_ff;
    } slvc_slice_t;

    typedef struct packed {
        logic red;
        logic green;
    } slvc_lamp_t;

endpackage : slvc_pkg

// [hdl/slvc_top.sv]
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module slvc_top
    import slvc_pkg::*;
#(
    parameter int FLASH_CYCLES = FLASH_CYC
)(
    input  wire logic                      SYS_CLK,
    input  wire logic                      NRST,
    input  wire logic                      PSEL,
    input  wire logic                      PENABLE,
    input  wire logic                      PWRITE,
    input  wire logic [7:0]                PADDR,
    input  wire logic [31:0]               PWDATA,
    output logic      [31:0]               PRDATA,
    output logic                           PREADY,
    output logic                           PSLVERR,
    input  wire slvc_slice_t               SLICE_A,
    input  wire slvc_slice_t               SLICE_B,
    input  wire slvc_slice_t               SLICE_C,
    input  wire logic                      EJ_TOP_CLOSED,
    input  wire logic                      EJ_BOT_CLOSED,
    output slvc_lamp_t [NUM_SLICE-1:0]     HEALTHY_LAMP,
    output slvc_lamp_t                     ACTIVE_LAMP,
    output slvc_lamp_t                     STANDBY_LAMP,
    output slvc_lamp_t                     EDUCATED_LAMP,
    output slvc_lamp_t [NUM_CH-1:0]        CH_LAMP,
    output logic                           IRQ
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [NUM_CH-1:0] vote(input logic [NUM_CH-1:0] a,
                                               input logic [NUM_CH-1:0] b,
                                               input logic [NUM_CH-1:0] c);
        vote = (a & b) | (a & c) | (b & c);
    endfunction : vote

    function automatic slvc_lamp_t lamp(input slvc_mode_t m, input logic fl);
        slvc_lamp_t l;
        l = '{red: 1'b0, green: 1'b0};
        unique case (m)
            M_OFF    : l = '{red: 1'b0, green: 1'b0};
            M_GRN    : l = '{red: 1'b0, green: 1'b1};
            M_RED    : l = '{red: 1'b1, green: 1'b0};
            M_GRN_FL : l = '{red: 1'b0, green: fl};
            M_RED_FL : l = '{red: fl,   green: 1'b0};
            M_AMB    : l = '{red: 1'b1, green: 1'b1};
            M_AMB_FL : l = '{red: fl,   green: fl};
            default  : l = '{red: 1'b0, green: 1'b0};
        endcase
        lamp = l;
    endfunction : lamp

    function automatic slvc_lamp_t health_lamp(input slvc_health_t h, input logic fl);
        slvc_mode_t m;
        m = M_OFF;
        unique case (h)
            H_NOPWR : m = M_OFF;
            H_PWRON : m = M_RED;
            H_START : m = M_AMB;
            H_OK    : m = M_GRN;
            H_FAULT : m = M_RED_FL;
            H_FATAL : m = M_RED;
            default : m = M_OFF;
        endcase
        health_lamp = lamp(m, fl);
    endfunction : health_lamp

    // ------------------------------------------------------------
    // Registers and wires
    // ------------------------------------------------------------
    localparam int FC_W = $clog2(FLASH_CYCLES + 1);

    logic [FC_W-1:0]       flash_cnt_q;
    logic                  flash_q;
    logic [2:0]            ej_top_sync_q;
    logic [2:0]            ej_bot_sync_q;
    logic                  ej_top_q;
    logic                  ej_bot_q;
    logic [MODE_TBL_W-1:0] out_mode_q;
    logic [MODE_TBL_W-1:0] fb_mode_q;
    logic [NUM_CH-1:0]     fb_sel_q;
    logic [IRQ_W-1:0]      irq_stat_q;
    logic [IRQ_W-1:0]      irq_mask_q;
    logic [31:0]           prdata_q;
    logic                  pslverr_q;
    slvc_lamp_t [NUM_SLICE-1:0] hl_q;
    slvc_lamp_t            act_q;
    slvc_lamp_t            stby_q;
    slvc_lamp_t            edu_q;
    slvc_lamp_t [NUM_CH-1:0]    ch_q;
    slvc_mod_t             mod_v;
    slvc_mod_t             mod_prev_q;
    logic [NUM_CH-1:0]     on_v;
    logic [NUM_CH-1:0]     ff_v;
    slvc_lamp_t [NUM_CH-1:0]    ch_d;
    slvc_lamp_t            act_d;
    slvc_lamp_t            stby_d;
    slvc_lamp_t            edu_d;
    logic                  flash_tick;
    logic                  ej_top_d;
    logic                  ej_bot_d;
    logic                  disagree;
    logic                  setup;
    logic                  wr_en;
    logic                  hit_stat;
    logic                  hit_istat;
    logic                  hit_imask;
    logic                  hit_omode;
    logic                  hit_fmode;
    logic                  hit_fsel_lo;
    logic                  hit_fsel_hi;
    logic                  hit_any;
    logic [31:0]           rd_mux;
    logic [IRQ_W-1:0]      irq_ev;
    logic [IRQ_W-1:0]      irq_stat_d;
    logic [NUM_CH-1:0]     mod_wide;

    // ------------------------------------------------------------
    // Majority vote of slice data
    // ------------------------------------------------------------
    assign mod_wide = vote({32'h0, SLICE_A.mod}, {32'h0, SLICE_B.mod}, {32'h0, SLICE_C.mod});
    assign mod_v    = slvc_mod_t'(mod_wide[$bits(slvc_mod_t)-1:0]);
    assign on_v     = vote(SLICE_A.ch_on, SLICE_B.ch_on, SLICE_C.ch_on);
    assign ff_v     = vote(SLICE_A.ch_ff, SLICE_B.ch_ff, SLICE_C.ch_ff);
    assign disagree = (SLICE_A.mod != SLICE_B.mod) || (SLICE_A.mod != SLICE_C.mod)
                   || (SLICE_A.ch_on != SLICE_B.ch_on) || (SLICE_A.ch_on != SLICE_C.ch_on)
                   || (SLICE_A.ch_ff != SLICE_B.ch_ff) || (SLICE_A.ch_ff != SLICE_C.ch_ff);

    // ------------------------------------------------------------
    // Shared flash timebase
    // ------------------------------------------------------------
    assign flash_tick = (flash_cnt_q == FC_W'(FLASH_CYCLES - 1));

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            flash_cnt_q <= '0;
            flash_q     <= 1'b0;
        end
        else
        begin
            flash_cnt_q <= flash_tick ? '0 : flash_cnt_q + 1'b1;
            flash_q     <= flash_q ^ flash_tick;
        end
    end

    // ------------------------------------------------------------
    // Module lamps
    // ------------------------------------------------------------
    assign act_d  = (mod_v.fatal || mod_v.shutdown) ? lamp(M_RED_FL, flash_q)
                  : (mod_v.active || mod_v.maintain) ? lamp(M_GRN, flash_q)
                  : lamp(M_OFF, flash_q);
    assign stby_d = mod_v.fatal ? lamp(M_RED_FL, flash_q)
                  : mod_v.standby ? lamp(M_GRN, flash_q)
                  : lamp(M_OFF, flash_q);
    assign edu_d  = mod_v.changeover ? lamp(M_AMB_FL, flash_q)
                  : mod_v.educated ? lamp(M_GRN, flash_q)
                  : mod_v.recognised ? lamp(M_GRN_FL, flash_q)
                  : lamp(M_OFF, flash_q);

    // ------------------------------------------------------------
    // Channel lamps
    // ------------------------------------------------------------
    always_comb
    begin
        logic [1:0]            st;
        logic [MODE_TBL_W-1:0] tbl;
        st  = 2'b00;
        tbl = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            st  = {ff_v[i], on_v[i]};
            tbl = fb_sel_q[i] ? fb_mode_q : out_mode_q;
            ch_d[i] = lamp(slvc_mode_t'(tbl[st*MODE_W +: MODE_W]), flash_q);
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            hl_q   <= '0;
            act_q  <= '0;
            stby_q <= '0;
            edu_q  <= '0;
            ch_q   <= '0;
        end
        else
        begin
            hl_q[0] <= health_lamp(SLICE_A.health, flash_q);
            hl_q[1] <= health_lamp(SLICE_B.health, flash_q);
            hl_q[2] <= health_lamp(SLICE_C.health, flash_q);
            act_q   <= act_d;
            stby_q  <= stby_d;
            edu_q   <= edu_d;
            ch_q    <= ch_d;
        end
    end

    assign HEALTHY_LAMP  = hl_q;
    assign ACTIVE_LAMP   = act_q;
    assign STANDBY_LAMP  = stby_q;
    assign EDUCATED_LAMP = edu_q;
    assign CH_LAMP       = ch_q;

    // ------------------------------------------------------------
    // Ejector lever switches
    // ------------------------------------------------------------
    assign ej_top_d = (ej_top_sync_q[1] == ej_top_sync_q[2]) ? ej_top_sync_q[2] : ej_top_q;
    assign ej_bot_d = (ej_bot_sync_q[1] == ej_bot_sync_q[2]) ? ej_bot_sync_q[2] : ej_bot_q;

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ej_top_sync_q <= '0;
            ej_bot_sync_q <= '0;
            ej_top_q      <= 1'b0;
            ej_bot_q      <= 1'b0;
            mod_prev_q    <= '0;
        end
        else
        begin
            ej_top_sync_q <= {ej_top_sync_q[1:0], EJ_TOP_CLOSED};
            ej_bot_sync_q <= {ej_bot_sync_q[1:0], EJ_BOT_CLOSED};
            ej_top_q      <= ej_top_d;
            ej_bot_q      <= ej_bot_d;
            mod_prev_q    <= mod_v;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign setup       = PSEL && !PENABLE;
    assign wr_en       = PSEL && PENABLE && PWRITE && hit_any;
    assign hit_stat    = (PADDR == OFS_STATUS);
    assign hit_istat   = (PADDR == OFS_IRQ_STAT);
    assign hit_imask   = (PADDR == OFS_IRQ_MASK);
    assign hit_omode   = (PADDR == OFS_OUT_MODE);
    assign hit_fmode   = (PADDR == OFS_FB_MODE);
    assign hit_fsel_lo = (PADDR == OFS_FB_SEL_LO);
    assign hit_fsel_hi = (PADDR == OFS_FB_SEL_HI);
    assign hit_any     = hit_stat | hit_istat | hit_imask | hit_omode | hit_fmode
                       | hit_fsel_lo | hit_fsel_hi;
    assign rd_mux      = hit_stat    ? {22'h0, ej_bot_q, ej_top_q, mod_v}
                       : hit_istat   ? {28'h0, irq_stat_q}
                       : hit_imask   ? {28'h0, irq_mask_q}
                       : hit_omode   ? {20'h0, out_mode_q}
                       : hit_fmode   ? {20'h0, fb_mode_q}
                       : hit_fsel_lo ? fb_sel_q[31:0]
                       : hit_fsel_hi ? {24'h0, fb_sel_q[NUM_CH-1:32]}
                       : 32'h0;

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end
        else if (setup)
        begin
            prdata_q  <= PWRITE ? 32'h0 : rd_mux;
            pslverr_q <= !hit_any;
        end
    end

    assign PRDATA  = prdata_q;
    assign PREADY  = 1'b1;
    assign PSLVERR = pslverr_q;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            out_mode_q <= RST_OUT_MODE;
            fb_mode_q  <= RST_FB_MODE;
            fb_sel_q   <= {RST_FB_SEL_HI, RST_FB_SEL_LO};
            irq_mask_q <= RST_IRQ_MASK;
        end
        else if (wr_en)
        begin
            if (hit_omode)
                out_mode_q <= PWDATA[MODE_TBL_W-1:0];
            if (hit_fmode)
                fb_mode_q <= PWDATA[MODE_TBL_W-1:0];
            if (hit_fsel_lo)
                fb_sel_q[31:0] <= PWDATA;
            if (hit_fsel_hi)
                fb_sel_q[NUM_CH-1:32] <= PWDATA[NUM_CH-33:0];
            if (hit_imask)
                irq_mask_q <= PWDATA[IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign irq_ev[IRQ_EJ_TOP]   = ej_top_d != ej_top_q;
    assign irq_ev[IRQ_EJ_BOT]   = ej_bot_d != ej_bot_q;
    assign irq_ev[IRQ_DISAGREE] = disagree;
    assign irq_ev[IRQ_FATAL]    = mod_v.fatal && !mod_prev_q.fatal;
    assign irq_stat_d = (irq_stat_q & ~((wr_en && hit_istat) ? PWDATA[IRQ_W-1:0] : '0)) | irq_ev;

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            irq_stat_q <= '0;
        else
            irq_stat_q <= irq_stat_d;
    end

    assign IRQ = |(irq_stat_q & irq_mask_q);

endmodule : slvc_top

// [sim/slvc_slice_model.sv]
`timescale 1ns/1ps
module slvc_slice_model
    import slvc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire slvc_slice_t cmd,
    input  wire slvc_slice_t odd,
    input  wire logic [1:0]  odd_sel,
    output slvc_slice_t      slice_a,
    output slvc_slice_t      slice_b,
    output slvc_slice_t      slice_c
);
    // Each slice reports its own copy; the selected one may disagree
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            slice_a <= '0;
            slice_b <= '0;
            slice_c <= '0;
        end
        else
        begin
            slice_a <= (odd_sel == 2'd0) ? odd : cmd;
            slice_b <= (odd_sel == 2'd1) ? odd : cmd;
            slice_c <= (odd_sel == 2'd2) ? odd : cmd;
        end
    end
endmodule : slvc_slice_model

// [sim/slvc_top_monitor.sv]
`timescale 1ns/1ps
module slvc_top_monitor
    import slvc_pkg::*;
#(
    parameter int FLASH_CYCLES = FLASH_CYC
)(
    input wire logic                       SYS_CLK,
    input wire logic                       NRST,
    input wire slvc_slice_t                SLICE_A,
    input wire slvc_slice_t                SLICE_B,
    input wire slvc_slice_t                SLICE_C,
    input wire slvc_lamp_t [NUM_SLICE-1:0] HEALTHY_LAMP,
    input wire slvc_lamp_t                 ACTIVE_LAMP,
    input wire slvc_lamp_t                 STANDBY_LAMP,
    input wire slvc_lamp_t                 EDUCATED_LAMP,
    input wire slvc_lamp_t [NUM_CH-1:0]    CH_LAMP,
    input wire logic                       IRQ
);
    // ----
    // Voted slice data
    // ----
    wire slvc_mod_t vm = slvc_mod_t'((SLICE_A.mod & SLICE_B.mod) | (SLICE_A.mod & SLICE_C.mod)
                                     | (SLICE_B.mod & SLICE_C.mod));
    wire logic [NUM_CH-1:0] von = (SLICE_A.ch_on & SLICE_B.ch_on) | (SLICE_A.ch_on & SLICE_C.ch_on)
                                  | (SLICE_B.ch_on & SLICE_C.ch_on);
    wire logic [NUM_CH-1:0] vff = (SLICE_A.ch_ff & SLICE_B.ch_ff) | (SLICE_A.ch_ff & SLICE_C.ch_ff)
                                  | (SLICE_B.ch_ff & SLICE_C.ch_ff);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    chk_active_green: assert property (!vm.fatal && !vm.shutdown && (vm.active || vm.maintain)
        |=> ACTIVE_LAMP == 2'b01) else $error("active lamp not green");
    chk_active_off: assert property (!vm.fatal && !vm.shutdown && !vm.active && !vm.maintain
        |=> ACTIVE_LAMP == 2'b00) else $error("active lamp not off");
    chk_fatal_both: assert property (vm.fatal
        |=> ACTIVE_LAMP == STANDBY_LAMP && !ACTIVE_LAMP.green) else $error("fatal lamps not paired red");
    chk_shut_stby_off: assert property (vm.shutdown && !vm.fatal && !vm.standby
        |=> STANDBY_LAMP == 2'b00 && !ACTIVE_LAMP.green) else $error("shutdown lamps wrong");
    chk_stby_green: assert property (vm.standby && !vm.fatal
        |=> STANDBY_LAMP == 2'b01) else $error("standby lamp not green");
    chk_chg_amber: assert property (vm.changeover
        |=> EDUCATED_LAMP.red == EDUCATED_LAMP.green) else $error("changeover lamp not amber");
    chk_edu_green: assert property (vm.educated && !vm.changeover
        |=> EDUCATED_LAMP == 2'b01) else $error("educated lamp not green");
    chk_health_ok: assert property (SLICE_A.health == H_OK
        |=> HEALTHY_LAMP[0] == 2'b01) else $error("healthy lamp not green");
    chk_health_fatal: assert property (SLICE_C.health == H_FATAL
        |=> HEALTHY_LAMP[2] == 2'b10) else $error("healthy lamp not red");
    chk_ch_fault_on: assert property (vff[0] && von[0] && vff[8] && von[8]
        |=> CH_LAMP[0] == 2'b11 && CH_LAMP[8] == 2'b11) else $error("faulted channel not amber");
    cov_fatal: cover property (vm.fatal);
    cov_changeover: cover property (vm.changeover);
    cov_irq: cover property ($rose(IRQ));
endmodule : slvc_top_monitor

bind slvc_top slvc_top_monitor #(.FLASH_CYCLES(FLASH_CYCLES)) u_mon (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .SLICE_A(SLICE_A), .SLICE_B(SLICE_B), .SLICE_C(SLICE_C),
    .HEALTHY_LAMP(HEALTHY_LAMP), .ACTIVE_LAMP(ACTIVE_LAMP), .STANDBY_LAMP(STANDBY_LAMP),
    .EDUCATED_LAMP(EDUCATED_LAMP), .CH_LAMP(CH_LAMP), .IRQ(IRQ));

// [sim/tb_status_led_vote_controller.sv]
`timescale 1ns/1ps
module tb_status_led_vote_controller
    import slvc_pkg::*;
;
    localparam int FL = 4;
    localparam logic [39:0] ONES = '1;
    logic SYS_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, EJ_TOP_CLOSED, EJ_BOT_CLOSED, err;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [1:0] odd_sel;
    logic [3:0] ml;
    logic [5:0] c0;
    logic [159:0] ce;
    slvc_slice_t SLICE_A, SLICE_B, SLICE_C, cmd, odd;
    slvc_lamp_t [NUM_SLICE-1:0] HEALTHY_LAMP;
    slvc_lamp_t ACTIVE_LAMP, STANDBY_LAMP, EDUCATED_LAMP;
    slvc_lamp_t [NUM_CH-1:0] CH_LAMP;
    int num_errors = 0;
    int num_checks = 0;
    typedef struct packed {
        logic [7:0] mod; slvc_health_t hl; logic [39:0] on; logic [39:0] ff; logic [11:0] ex; logic [11:0] fl;
    } slvc_row_t;
    slvc_row_t rows [8] = '{'{8'h80, H_OK, ONES, 40'h0, 12'h550, 12'h000},
        '{8'h40, H_PWRON, 40'haaaaaaaaaa, 40'h8888888888, 12'ha90, 12'h000},
        '{8'h24, H_START, ONES, 40'h0, 12'hfc5, 12'h000}, '{8'h00, H_NOPWR, 40'h0, 40'h0, 12'h000, 12'h000},
        '{8'h28, H_FATAL, 40'h0, ONES, 12'ha80, 12'h028}, '{8'h92, H_FAULT, 40'h0, 40'hf0f0f0f0f0, 12'h000, 12'haa1},
        '{8'h05, H_OK, ONES, ONES, 12'h540, 12'h003}, '{8'h06, H_OK, ONES, ONES, 12'h541, 12'h000}};

    slvc_top #(.FLASH_CYCLES(FL)) u_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .SLICE_A(SLICE_A), .SLICE_B(SLICE_B), .SLICE_C(SLICE_C), .EJ_TOP_CLOSED(EJ_TOP_CLOSED),
        .EJ_BOT_CLOSED(EJ_BOT_CLOSED), .HEALTHY_LAMP(HEALTHY_LAMP), .ACTIVE_LAMP(ACTIVE_LAMP),
        .STANDBY_LAMP(STANDBY_LAMP), .EDUCATED_LAMP(EDUCATED_LAMP), .CH_LAMP(CH_LAMP), .IRQ(IRQ));
    slvc_slice_model u_slices (.clk(SYS_CLK), .nrst(NRST), .cmd(cmd), .odd(odd), .odd_sel(odd_sel),
        .slice_a(SLICE_A), .slice_b(SLICE_B), .slice_c(SLICE_C));

    // ----
    // Helpers
    // ----
    function automatic logic [3:0] mode_lamp(input logic [2:0] code);
        case (code)
            3'd1: return 4'b0100;
            3'd2: return 4'b1000;
            3'd3: return 4'b0001;
            3'd4: return 4'b0010;
            3'd5: return 4'b1100;
            3'd6: return 4'b0011;
            default: return 4'b0000;
        endcase
    endfunction : mode_lamp

    function automatic logic [159:0] exp_ch(input logic [39:0] on, input logic [39:0] ff);
        logic [79:0] st;
        logic [79:0] fl;
        logic [3:0] lp;
        for (int i = 0; i < NUM_CH; i++)
        begin
            lp = mode_lamp(!ff[i] ? (on[i] ? ((i >= 8 && i <= 31) ? 3'd1 : 3'd2) : 3'd0) : (on[i] ? 3'd5 : 3'd6));
            st[2*i +: 2] = lp[3:2];
            fl[2*i +: 2] = lp[1:0];
        end
        return {st, fl};
    endfunction : exp_ch

    task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= addr;
        PWDATA <= wdata;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        @(posedge SYS_CLK);
        while (PREADY !== 1'b1) @(posedge SYS_CLK);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(name, {err, rd}, {1'b0, exp});
    endtask : rd_chk

    task automatic drive(input logic [7:0] mod, input slvc_health_t hl, input logic [39:0] on, input logic [39:0] ff);
        @(posedge SYS_CLK);
        cmd <= '{health: hl, mod: mod, ch_on: on, ch_ff: ff};
    endtask : drive

    task automatic look(input logic [11:0] ex, input logic [11:0] fl, input logic [159:0] c);
        logic [11:0] m0;
        logic [79:0] k0;
        repeat (3) @(posedge SYS_CLK);
        #1;
        m0 = {HEALTHY_LAMP, ACTIVE_LAMP, STANDBY_LAMP, EDUCATED_LAMP};
        k0 = CH_LAMP;
        repeat (FL) @(posedge SYS_CLK);
        #1;
        check("mod_lamps", m0 & ~fl, ex);
        check("mod_flash", m0 ^ {HEALTHY_LAMP, ACTIVE_LAMP, STANDBY_LAMP, EDUCATED_LAMP}, fl);
        check("ch_lamps", k0 & ~c[79:0], c[159:80]);
        check("ch_flash", k0 ^ CH_LAMP, c[79:0]);
    endtask : look

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    initial
    begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end

    initial
    begin
        repeat (4000) @(posedge SYS_CLK);
        num_errors++;
        wrap_up();
    end

    // ----
    // Main sequence
    // ----
    initial
    begin
        {NRST, PSEL, PENABLE, PWRITE, EJ_TOP_CLOSED, EJ_BOT_CLOSED, PADDR, PWDATA} = '0;
        cmd = '0;
        odd = '0;
        odd_sel = 2'd3;
        repeat (6) @(posedge SYS_CLK);
        check("rst_out", {CH_LAMP[0], HEALTHY_LAMP, ACTIVE_LAMP, IRQ, PSLVERR}, 80'h0);
        NRST <= 1'b1;
        rd_chk("out_mode", OFS_OUT_MODE, 32'h00000b90);
        rd_chk("fb_mode", OFS_FB_MODE, 32'h00000b88);
        rd_chk("fb_sel_lo", OFS_FB_SEL_LO, 32'hffffff00);
        rd_chk("fb_sel_hi", OFS_FB_SEL_HI, 32'h0);
        rd_chk("irq_mask", OFS_IRQ_MASK, 32'h0);
        $display("defaults done");
        foreach (rows[i])
        begin
            drive(rows[i].mod, rows[i].hl, rows[i].on, rows[i].ff);
            look(rows[i].ex, rows[i].fl, exp_ch(rows[i].on, rows[i].ff));
        end
        $display("rows done");
        rd_chk("fatal_irq", OFS_IRQ_STAT, 32'h8);
        apb(1'b1, OFS_IRQ_STAT, 32'hf);
        drive(8'h80, H_OK, ONES, 40'h0);
        odd <= '{health: H_FATAL, mod: 8'h20, ch_on: 40'h0, ch_ff: ONES};
        odd_sel <= 2'd1;
        look(12'h650, 12'h0, exp_ch(ONES, 40'h0));
        rd_chk("disagree", OFS_IRQ_STAT, 32'h4);
        odd_sel <= 2'd3;
        apb(1'b1, OFS_IRQ_STAT, 32'h4);
        rd_chk("agree", OFS_IRQ_STAT, 32'h0);
        $display("vote done");
        EJ_TOP_CLOSED <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        rd_chk("ej_top", OFS_STATUS, 32'h180);
        rd_chk("ej_top_irq", OFS_IRQ_STAT, 32'h1);
        check("irq_masked", IRQ, 1'b0);
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        #1;
        check("irq_on", IRQ, 1'b1);
        apb(1'b1, OFS_IRQ_STAT, 32'h1);
        #1;
        check("irq_clr", IRQ, 1'b0);
        EJ_TOP_CLOSED <= 1'b0;
        EJ_BOT_CLOSED <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        rd_chk("ej_bot", OFS_STATUS, 32'h280);
        rd_chk("ej_bot_irq", OFS_IRQ_STAT, 32'h3);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", {err, rd}, {1'b1, 32'h0});
        $display("irq done");
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, OFS_OUT_MODE, {20'h0, 3'd5, 3'd6, k[2:0], 3'd0});
            ml = mode_lamp(k[2:0]);
            repeat (3) @(posedge SYS_CLK);
            #1;
            c0 = {CH_LAMP[39], CH_LAMP[8], CH_LAMP[0]};
            repeat (FL) @(posedge SYS_CLK);
            #1;
            check("cfg_lamp", c0 & ~{ml[1:0], 2'b00, ml[1:0]}, {ml[3:2], 2'b01, ml[3:2]});
            check("cfg_flash", c0 ^ {CH_LAMP[39], CH_LAMP[8], CH_LAMP[0]}, {ml[1:0], 2'b00, ml[1:0]});
        end
        $display("config done");
        @(posedge SYS_CLK);
        NRST <= 1'b0;
        @(posedge SYS_CLK);
        #1;
        check("rst_mid", {CH_LAMP[0], ACTIVE_LAMP, IRQ}, 80'h0);
        @(posedge SYS_CLK);
        NRST <= 1'b1;
        rd_chk("out_mode2", OFS_OUT_MODE, 32'h00000b90);
        rd_chk("irq_mask2", OFS_IRQ_MASK, 32'h0);
        $display("reset done");
        wrap_up();
    end
endmodule : tb_status_led_vote_controller
